// file: include/mcast_path_pkg.sv
// Shared constants and types for the multicast ingress path manager
package mcast_path_pkg;

    // ==========================================================
    // Fabric multicast paths
    localparam int PATHS_WIDE = 16;
    localparam int PRIMARY_COUNT_WIDE = 15;
    localparam logic [3:0] PATH_HI_WIDE = 4'h0;
    localparam logic [3:0] PATH_LO_WIDE = 4'hf;
    localparam logic [3:0] PATH_HI_NARROW = 4'h0;
    localparam logic [3:0] PATH_ANC_NARROW = 4'h1;
    localparam logic [3:0] PATH_LO_NARROW = 4'h2;
    localparam logic [15:0] MASK_DEFAULT_WIDE = 16'h8001;
    localparam logic [15:0] MASK_FULL_WIDE = 16'hffff;
    localparam logic [15:0] MASK_DEFAULT_NARROW = 16'h0005;
    localparam logic [15:0] MASK_MGMT_NARROW = 16'h0007;

    // ==========================================================
    // Forwarding classes: bit set marks an expedited class
    localparam logic [7:0] EXPEDITED_FC_MASK = 8'he0;

    // ==========================================================
    // Shared queue defaults, peak equal to committed
    localparam logic [23:0] DEF_SHARED_RATE = 24'h0f4240;
    localparam logic [15:0] DEF_COMMITTED_BURST = 16'h0400;
    localparam logic [15:0] DEF_MAXIMUM_BURST = 16'h1000;
    localparam logic [15:0] DEF_HI_ONLY = 16'h0200;

    // ==========================================================
    // Flow rate sampling interval
    localparam int CLOCK_MHZ = 100;
    localparam int SAMPLE_US = 100;
    localparam int SAMPLE_CYCLES = SAMPLE_US * CLOCK_MHZ;

    // ==========================================================
    // Types
    typedef enum logic [2:0]
    {
        QUEUE_IFACE = 3'b001,
        QUEUE_MANAGED = 3'b010,
        QUEUE_UNMANAGED = 3'b100
    } queue_kind_e;

    typedef enum logic [2:0]
    {
        CLASS_PRIMARY = 3'b001,
        CLASS_ANCILLARY = 3'b010,
        CLASS_SECONDARY = 3'b100
    } path_class_e;

endpackage

// file: hw/path_assigner.sv
// Preference-ordered placement of managed flows onto fabric paths
`timescale 1ns/1ns
module path_assigner
    import mcast_path_pkg::*;
#(
    parameter int NUM_FLOWS = 8,
    parameter int PREF_W = 4,
    parameter int RATE_W = 24
)
(
    // Configuration
    input wire logic three_path,
    input wire logic [RATE_W-1:0] primary_limit,
    input wire logic [RATE_W-1:0] ancillary_limit,
    // Flow table
    input wire logic [NUM_FLOWS-1:0] flow_on,
    input wire logic [NUM_FLOWS-1:0][PREF_W-1:0] flow_pref,
    input wire logic [NUM_FLOWS-1:0][RATE_W-1:0] flow_rate,
    // Placement
    output logic [NUM_FLOWS-1:0][3:0] flow_path,
    output path_class_e [NUM_FLOWS-1:0] flow_class,
    output logic [NUM_FLOWS-1:0] flow_top
);
    localparam int SUM_W = RATE_W + $clog2(NUM_FLOWS) + 2;

    logic [NUM_FLOWS-1:0][SUM_W-1:0] need;

    function automatic logic ahead(input int j, input int i,
                                   input logic [NUM_FLOWS-1:0][PREF_W-1:0] p);
        ahead = (p[j] > p[i]) || ((p[j] == p[i]) && (j < i));
    endfunction

    // ==========================================================
    // Bandwidth needed by a flow and all enabled flows that rank above it
    always_comb
    begin
        need = '0;
        for (int i = 0; i < NUM_FLOWS; i++)
        begin
            need[i] = SUM_W'(flow_rate[i]);
            for (int j = 0; j < NUM_FLOWS; j++)
            begin
                if (j != i && flow_on[j] && ahead(j, i, flow_pref))
                begin
                    need[i] = need[i] + SUM_W'(flow_rate[j]);
                end
            end
        end
    end

    // Primary first, then ancillary on the three-path card, then secondary
    always_comb
    begin
        for (int i = 0; i < NUM_FLOWS; i++)
        begin
            if (need[i] <= SUM_W'(primary_limit))
            begin
                flow_class[i] = CLASS_PRIMARY;
                flow_path[i] = three_path ? PATH_HI_NARROW : 4'(i);
            end
            else if (three_path &&
                     need[i] <= SUM_W'(primary_limit) + SUM_W'(ancillary_limit))
            begin
                flow_class[i] = CLASS_ANCILLARY;
                flow_path[i] = PATH_ANC_NARROW;
            end
            else
            begin
                flow_class[i] = CLASS_SECONDARY;
                flow_path[i] = three_path ? PATH_LO_NARROW : PATH_LO_WIDE;
            end
        end
    end

    // A flow is top when no enabled higher-ranked flow shares its path
    always_comb
    begin
        flow_top = '1;
        for (int i = 0; i < NUM_FLOWS; i++)
        begin
            for (int j = 0; j < NUM_FLOWS; j++)
            begin
                if (j != i && flow_on[j] && flow_path[j] == flow_path[i] &&
                    ahead(j, i, flow_pref))
                begin
                    flow_top[i] = 1'b0;
                end
            end
        end
    end

endmodule // path_assigner

// file: hw/mcast_ingress_path_manager.sv
// Ingress multicast path and queue selection toward the switch fabric
`timescale 1ns/1ns
module mcast_ingress_path_manager
    import mcast_path_pkg::*;
#(
    parameter int NUM_FLOWS = 8,
    parameter int PREF_W = 4,
    parameter int RATE_W = 24,
    parameter int IFACE_W = 6,
    parameter int SAMPLE_COUNT = SAMPLE_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Card and adapter configuration
    input wire logic three_path,
    input wire logic mgmt_enable,
    input wire logic p2mp_ilm_present,
    input wire logic [RATE_W-1:0] primary_limit,
    input wire logic [RATE_W-1:0] ancillary_limit,
    // Flow table writes
    input wire logic flow_we,
    input wire logic [$clog2(NUM_FLOWS)-1:0] flow_idx,
    input wire logic [PREF_W-1:0] flow_pref_in,
    input wire logic flow_on_in,
    // Shared queue configuration
    input wire logic queue_we,
    input wire logic [23:0] queue_peak_in,
    input wire logic [23:0] queue_committed_in,
    input wire logic [15:0] queue_burst_in,
    input wire logic [15:0] queue_max_burst_in,
    input wire logic [15:0] queue_hi_only_in,
    // Path congestion from the fabric
    input wire logic [15:0] path_congested,
    // Ingress packets from the classifier
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [IFACE_W-1:0] in_iface,
    input wire logic [2:0] in_fc,
    input wire logic in_prio,
    input wire logic in_p2mp,
    input wire logic in_branch_copy,
    input wire logic in_record_match,
    input wire logic [$clog2(NUM_FLOWS)-1:0] in_flow,
    input wire logic [15:0] in_len,
    // Decisions to the fabric
    output logic out_valid,
    input wire logic out_ready,
    output logic [3:0] out_path,
    output queue_kind_e out_queue,
    output logic [IFACE_W-1:0] out_iface,
    output logic [2:0] out_fc,
    output logic out_prio,
    output logic out_drop,
    // Status
    output logic [15:0] path_enabled,
    output logic [23:0] committed_burst_threshold,
    output logic [23:0] shared_peak_rate,
    output logic [23:0] shared_committed_rate,
    output logic [15:0] maximum_burst_threshold,
    output logic [15:0] shared_hi_only
);
    localparam int FLOW_W = $clog2(NUM_FLOWS);
    localparam int CNT_W = $clog2(SAMPLE_COUNT);

    if (NUM_FLOWS < 2 || NUM_FLOWS > 8 || NUM_FLOWS != (1 << FLOW_W))
    begin : g_flows_bad
        $error("NUM_FLOWS must be a power of two from 2 to 8");
    end
    if (SAMPLE_COUNT < 2 || RATE_W < 16 || IFACE_W < 1)
    begin : g_sizes_bad
        $error("SAMPLE_COUNT, RATE_W or IFACE_W out of range");
    end

    function automatic logic is_expedited(input logic [2:0] fc);
        is_expedited = EXPEDITED_FC_MASK[fc];
    endfunction

    logic [NUM_FLOWS-1:0] flow_on_r;
    logic [NUM_FLOWS-1:0][PREF_W-1:0] flow_pref_r;
    logic [NUM_FLOWS-1:0][RATE_W-1:0] acc_r;
    logic [NUM_FLOWS-1:0][RATE_W-1:0] rate_r;
    logic [NUM_FLOWS-1:0][3:0] flow_path;
    path_class_e [NUM_FLOWS-1:0] flow_class;
    logic [NUM_FLOWS-1:0] flow_top;
    logic [CNT_W-1:0] tick_cnt_r;
    logic tick;
    logic accept;
    logic managed_nxt;
    logic [3:0] path_nxt;
    queue_kind_e queue_nxt;
    logic drop_nxt;
    logic [15:0] mask_nxt;

    // ==========================================================
    // Sampling interval divider
    assign tick = (tick_cnt_r == CNT_W'(SAMPLE_COUNT - 1));

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end

    // ==========================================================
    // Flow table
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            flow_on_r <= '0;
            flow_pref_r <= '0;
        end
        else if (flow_we)
        begin
            flow_on_r[flow_idx] <= flow_on_in;
            flow_pref_r[flow_idx] <= flow_pref_in;
        end
    end

    // Bytes per interval; a packet that would overflow is not added, so the count holds rather than wrapping to a low rate
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_r <= '0;
            rate_r <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_FLOWS; i++)
            begin
                if (tick)
                begin
                    rate_r[i] <= acc_r[i];
                    // A packet taken on the tick opens the next interval, not lost
                    acc_r[i] <= (accept && managed_nxt && in_flow == FLOW_W'(i)) ?
                                RATE_W'(in_len) : '0;
                end
                else if (accept && managed_nxt && in_flow == FLOW_W'(i) &&
                         acc_r[i] <= {RATE_W{1'b1}} - RATE_W'(in_len))
                begin
                    acc_r[i] <= acc_r[i] + RATE_W'(in_len);
                end
            end
        end
    end

    path_assigner #(
        .NUM_FLOWS(NUM_FLOWS),
        .PREF_W(PREF_W),
        .RATE_W(RATE_W)
    ) u_assigner (
        .three_path(three_path),
        .primary_limit(primary_limit),
        .ancillary_limit(ancillary_limit),
        .flow_on(flow_on_r),
        .flow_pref(flow_pref_r),
        .flow_rate(rate_r),
        .flow_path(flow_path),
        .flow_class(flow_class),
        .flow_top(flow_top)
    );

    // ==========================================================
    // Shared queue settings, common to every shared queue
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            shared_peak_rate <= DEF_SHARED_RATE;
            shared_committed_rate <= DEF_SHARED_RATE;
            committed_burst_threshold <= 24'(DEF_COMMITTED_BURST);
            maximum_burst_threshold <= DEF_MAXIMUM_BURST;
            shared_hi_only <= DEF_HI_ONLY;
        end
        else if (queue_we)
        begin
            shared_peak_rate <= queue_peak_in;
            shared_committed_rate <= queue_committed_in;
            committed_burst_threshold <= 24'(queue_burst_in);
            maximum_burst_threshold <= queue_max_burst_in;
            shared_hi_only <= queue_hi_only_in;
        end
    end

    // ==========================================================
    // Path enables
    always_comb
    begin
        if (three_path)
            mask_nxt = mgmt_enable ? MASK_MGMT_NARROW : MASK_DEFAULT_NARROW;
        else if (mgmt_enable || p2mp_ilm_present)
            mask_nxt = MASK_FULL_WIDE;
        else
            mask_nxt = MASK_DEFAULT_WIDE;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            path_enabled <= MASK_DEFAULT_WIDE;
        else
            path_enabled <= mask_nxt;
    end

    // ==========================================================
    // Per-packet decision
    always_comb
    begin
        managed_nxt = mgmt_enable && in_record_match && !in_branch_copy &&
                      flow_on_r[in_flow];
        drop_nxt = 1'b0;
        if (managed_nxt)
        begin
            queue_nxt = QUEUE_MANAGED;
            path_nxt = flow_path[in_flow];
            // Overflow on the wide card has no legal path, so it is shed
            if (!three_path && flow_class[in_flow] == CLASS_SECONDARY)
                drop_nxt = 1'b1;
            if (path_congested[path_nxt] && !flow_top[in_flow])
                drop_nxt = 1'b1;
        end
        else if (in_p2mp && !three_path)
        begin
            queue_nxt = QUEUE_UNMANAGED;
            path_nxt = 4'(in_flow);
        end
        else
        begin
            queue_nxt = QUEUE_IFACE;
            if (three_path)
                path_nxt = is_expedited(in_fc) ? PATH_HI_NARROW : PATH_LO_NARROW;
            else
                path_nxt = is_expedited(in_fc) ? PATH_HI_WIDE : PATH_LO_WIDE;
        end
    end

    // Output stage holds one decision; a stalled fabric stalls the classifier
    assign in_ready = out_ready || !out_valid;
    assign accept = in_valid && in_ready;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            out_valid <= 1'b0;
        else if (in_ready)
            out_valid <= in_valid;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            out_path <= '0;
            out_queue <= QUEUE_IFACE;
            out_iface <= '0;
            out_fc <= '0;
            out_prio <= 1'b0;
            out_drop <= 1'b0;
        end
        else if (accept)
        begin
            out_path <= path_nxt;
            out_queue <= queue_nxt;
            out_iface <= in_iface;
            out_fc <= in_fc;
            out_prio <= in_prio;
            out_drop <= drop_nxt;
        end
    end

    // ==========================================================
    // Checks
    sequence take_s;
        in_valid && in_ready;
    endsequence

    sequence iface_out_s;
        out_valid && out_queue == QUEUE_IFACE;
    endsequence

    sequence branch_take_s;
        take_s ##0 in_branch_copy;
    endsequence

    default_path_a: assert property (@(posedge clock) disable iff (!resetn)
        iface_out_s |-> (out_path == (is_expedited(out_fc) ? 4'h0 :
                                      (three_path ? 4'h2 : 4'hf))))
        else $error("interface queue on wrong default path");

    wide_mask_a: assert property (@(posedge clock) disable iff (!resetn)
        (!three_path && !mgmt_enable && !p2mp_ilm_present) [*2]
        |-> path_enabled == 16'h8001)
        else $error("wide card default mask wrong");

    wide_full_a: assert property (@(posedge clock) disable iff (!resetn)
        (!three_path && (mgmt_enable || p2mp_ilm_present)) ##1
        (!three_path && (mgmt_enable || p2mp_ilm_present))
        |-> path_enabled == 16'hffff)
        else $error("wide card paths not all enabled");

    narrow_mask_a: assert property (@(posedge clock) disable iff (!resetn)
        $past(three_path) && $past(mgmt_enable) |-> path_enabled == 16'h0007)
        else $error("ancillary path not enabled");

    secondary_clean_a: assert property (@(posedge clock) disable iff (!resetn)
        out_valid && !$past(three_path) && out_queue != QUEUE_IFACE && !out_drop
        |-> out_path != 4'hf)
        else $error("secondary carries shared queue traffic");

    branch_unmanaged_a: assert property (@(posedge clock) disable iff (!resetn)
        branch_take_s |=> out_valid && out_queue != QUEUE_MANAGED)
        else $error("branch copy treated as managed");

    off_unmanaged_a: assert property (@(posedge clock) disable iff (!resetn)
        take_s ##0 !mgmt_enable |=> out_queue != QUEUE_MANAGED && !out_drop)
        else $error("managed with management off");

    stall_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        out_valid && !out_ready |=> out_valid && $stable(out_path) &&
                                    $stable(out_queue) && $stable(out_iface))
        else $error("decision changed while stalled");

    congest_drop_a: assert property (@(posedge clock) disable iff (!resetn)
        take_s ##0 (managed_nxt && path_congested[flow_path[in_flow]] &&
                    !flow_top[in_flow]) |=> out_drop)
        else $error("lower preference flow not discarded");

    rate_latch_a: assert property (@(posedge clock) disable iff (!resetn)
        tick ##0 !(accept && managed_nxt && in_flow == '0)
        |=> rate_r[0] == $past(acc_r[0]) && acc_r[0] == '0)
        else $error("flow rate not sampled at interval end");

    tick_open_a: assert property (@(posedge clock) disable iff (!resetn)
        tick ##0 (accept && managed_nxt && in_flow == '0)
        |=> rate_r[0] == $past(acc_r[0]) && acc_r[0] == RATE_W'($past(in_len)))
        else $error("packet on interval edge not counted");

    queue_default_a: assert property (@(posedge clock) disable iff (!resetn)
        !queue_we ##1 !queue_we |-> $stable(shared_peak_rate) &&
                                    $stable(shared_committed_rate))
        else $error("shared queue settings changed without a write");

endmodule // mcast_ingress_path_manager

// file: sim/fabric_model.sv
// Fabric side model: takes decisions promptly or with random stalls
`timescale 1ns/1ns
module fabric_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Pacing and handshake
    input wire logic stall_en,
    output logic out_ready
);
    // ==========================================================
    // Ready moves only at the falling edge, clear of sampling
    always @(negedge clock or negedge resetn)
    begin
        if (!resetn)
            out_ready <= 1'b0;
        else
            out_ready <= !stall_en || ($urandom % 3 != 0);
    end
endmodule // fabric_model

// file: sim/test_multicast_ingress_path_manager.sv
// Self-checking bench for the multicast ingress path manager
`timescale 1ns/1ns
module test_multicast_ingress_path_manager
    import mcast_path_pkg::*;
;
    // ==========================================================
    // Design ports and bench state
    logic clock = 1'b0, resetn = 1'b0, three_path = 1'b0, mgmt_enable = 1'b0;
    logic p2mp_ilm_present = 1'b0, flow_we = 1'b0, flow_on_in = 1'b0, queue_we = 1'b0;
    logic in_valid = 1'b0, in_prio = 1'b0, in_p2mp = 1'b0, in_branch_copy = 1'b0;
    logic in_record_match = 1'b0, stall_en = 1'b0, mchk = 1'b0;
    logic [23:0] primary_limit = 24'h0, ancillary_limit = 24'h0;
    logic [23:0] queue_peak_in = 24'h0, queue_committed_in = 24'h0;
    logic [15:0] queue_burst_in = 16'h0, queue_max_burst_in = 16'h0, queue_hi_only_in = 16'h0;
    logic [15:0] path_congested = 16'h0, in_len = 16'h0;
    logic [5:0] in_iface = 6'h0;
    logic [3:0] flow_pref_in = 4'h0;
    logic [2:0] flow_idx = 3'h0, in_fc = 3'h0, in_flow = 3'h0;
    logic in_ready, out_valid, out_ready, out_prio, out_drop;
    logic [3:0] out_path;
    queue_kind_e out_queue;
    logic [5:0] out_iface;
    logic [2:0] out_fc;
    logic [15:0] path_enabled, maximum_burst_threshold, shared_hi_only;
    logic [23:0] committed_burst_threshold, shared_peak_rate, shared_committed_rate;
    int num_errors = 0, n_checks = 0;
    logic [3:0] pref_t [8];
    logic [23:0] rate_t [4];
    logic [18:0] expq [$];
    logic [18:0] e;

    mcast_ingress_path_manager #(.SAMPLE_COUNT(16)) dut_u
    (
        .clock, .resetn, .three_path, .mgmt_enable, .p2mp_ilm_present, .primary_limit,
        .ancillary_limit, .flow_we, .flow_idx, .flow_pref_in, .flow_on_in, .queue_we,
        .queue_peak_in, .queue_committed_in, .queue_burst_in, .queue_max_burst_in,
        .queue_hi_only_in, .path_congested, .in_valid, .in_ready, .in_iface, .in_fc,
        .in_prio, .in_p2mp, .in_branch_copy, .in_record_match, .in_flow, .in_len,
        .out_valid, .out_ready, .out_path, .out_queue, .out_iface, .out_fc, .out_prio,
        .out_drop, .path_enabled, .committed_burst_threshold, .shared_peak_rate,
        .shared_committed_rate, .maximum_burst_threshold, .shared_hi_only
    );
    fabric_model partner_u (.clock, .resetn, .stall_en, .out_ready);

    initial
        forever #5 clock = ~clock;

    // ==========================================================
    // Checking and expectations
    task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic ahead(int g, int f);
        return g != f && (pref_t[g] > pref_t[f] || (pref_t[g] == pref_t[f] && g < f));
    endfunction

    // Placement by rank against the pooled limits, flows 0..3 are the live ones
    function automatic logic [3:0] mpath(int f);
        logic [24:0] cum;
        cum = 25'(rate_t[f]);
        for (int g = 0; g < 4; g++)
            if (ahead(g, f))
                cum += rate_t[g];
        if (cum <= primary_limit)
            return three_path ? PATH_HI_NARROW : 4'(f);
        if (three_path && cum <= primary_limit + ancillary_limit)
            return PATH_ANC_NARROW;
        return three_path ? PATH_LO_NARROW : PATH_LO_WIDE;
    endfunction

    function automatic logic [18:0] expect_dec();
        logic drop;
        logic [3:0] p;
        int f;
        f = in_flow;
        if (mgmt_enable && in_record_match && !in_branch_copy && f < 4)
        begin
            p = mpath(f);
            drop = !three_path && p == PATH_LO_WIDE;
            for (int g = 0; g < 4; g++)
                if (ahead(g, f) && mpath(g) == p && path_congested[p])
                    drop = 1'b1;
            return {!mchk, p, QUEUE_MANAGED, in_iface, in_fc, in_prio, drop};
        end
        if (in_p2mp && !three_path)
            return {2'b0, in_flow, QUEUE_UNMANAGED, in_iface, in_fc, in_prio, 1'b0};
        p = EXPEDITED_FC_MASK[in_fc] ? 4'h0 : (three_path ? PATH_LO_NARROW : PATH_LO_WIDE);
        return {1'b0, p, QUEUE_IFACE, in_iface, in_fc, in_prio, 1'b0};
    endfunction

    always @(posedge clock)
    begin
        if (out_valid && out_ready)
        begin
            e = expq.size() != 0 ? expq.pop_front() : 19'h3ffff;
            if (!e[18])
                chk("decision", 128'(e[17:0]), {out_path, out_queue, out_iface, out_fc,
                    out_prio, out_drop});
        end
        if (in_valid && in_ready)
            expq.push_back(expect_dec());
    end

    // ==========================================================
    // Drivers
    task automatic send(logic [2:0] fl, logic p2, logic br, logic rm);
        @(negedge clock);
        in_valid = 1'b1;
        {in_flow, in_p2mp, in_branch_copy, in_record_match} = {fl, p2, br, rm};
        {in_iface, in_fc, in_prio} = 10'($urandom);
        in_len = 16'h0100;
        @(posedge clock);
        while (!in_ready)
            @(posedge clock);
    endtask

    task automatic idle();
        @(negedge clock);
        in_valid = 1'b0;
        for (int i = 0; i < 50 && expq.size() != 0; i++)
            @(negedge clock);
        chk("pending decisions", 128'h0, 128'(expq.size()));
    endtask

    task automatic cfg(logic tp, logic mg, logic ilm, logic [15:0] pe);
        @(negedge clock);
        {three_path, mgmt_enable, p2mp_ilm_present} = {tp, mg, ilm};
        @(negedge clock);
        chk("path_enabled", 128'(pe), 128'(path_enabled));
    endtask

    task automatic stop_test();
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        stop_test();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h4d97));
        repeat (20) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        chk("reset settings", {DEF_SHARED_RATE, DEF_SHARED_RATE, 8'h0, DEF_COMMITTED_BURST,
            DEF_MAXIMUM_BURST, DEF_HI_ONLY}, {shared_peak_rate, shared_committed_rate,
            committed_burst_threshold, maximum_burst_threshold, shared_hi_only});
        cfg(1'b0, 1'b0, 1'b0, MASK_DEFAULT_WIDE);
        cfg(1'b0, 1'b0, 1'b1, MASK_FULL_WIDE);
        cfg(1'b1, 1'b0, 1'b0, MASK_DEFAULT_NARROW);
        cfg(1'b1, 1'b1, 1'b0, MASK_MGMT_NARROW);
        cfg(1'b0, 1'b1, 1'b0, MASK_FULL_WIDE);
        queue_we = 1'b1;
        {queue_peak_in, queue_committed_in} = 48'({$urandom, $urandom});
        {queue_burst_in, queue_max_burst_in, queue_hi_only_in} = 48'({$urandom, $urandom});
        @(negedge clock);
        queue_we = 1'b0;
        chk("queue settings", {queue_peak_in, queue_committed_in, 8'h0, queue_burst_in,
            queue_max_burst_in, queue_hi_only_in}, {shared_peak_rate, shared_committed_rate,
            committed_burst_threshold, maximum_burst_threshold, shared_hi_only});
        // Flows 0..3 live with distinct preferences, 4..7 stay off
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clock);
            {flow_we, flow_idx, flow_on_in} = {1'b1, 3'(i), i < 4};
            flow_pref_in = 4'(i * 5 + 3);
            pref_t[i] = flow_pref_in;
            @(negedge clock);
            flow_we = 1'b0;
        end
        stall_en = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            cfg(m[0], m[1], 1'b1, m[0] ? (m[1] ? MASK_MGMT_NARROW : MASK_DEFAULT_NARROW)
                : MASK_FULL_WIDE);
            repeat (40) send(3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
            idle();
        end
        // Steady round robin: each flow carries four packets per interval
        stall_en = 1'b0;
        primary_limit = 24'h000800;
        ancillary_limit = 24'h000400;
        foreach (rate_t[i])
            rate_t[i] = 24'h000400;
        for (int m = 0; m < 4; m++)
        begin
            cfg(m[0], 1'b1, 1'b0, m[0] ? MASK_MGMT_NARROW : MASK_FULL_WIDE);
            path_congested = m[1] ? 16'h0003 : 16'h0000;
            for (int k = 0; k < 96; k++)
            begin
                mchk = k >= 64;
                send(3'(k % 4), 1'b1, 1'b0, 1'b1);
            end
            idle();
            mchk = 1'b0;
        end
        stop_test();
    end
endmodule // test_multicast_ingress_path_manager
